// ### include/pfm_pkg.sv
// Package for the protection and fault manager of a step-down regulator.
// Assumes a 10 MHz APB clock and millivolt / degree sense codes.
package pfm_pkg;
   // Register byte offsets.
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_THRESH = 8'h08;
   // Control word fields (propagation_config and protection_type_config).
   localparam int C_PG95  = 1;
   localparam int C_TCDIS = 2;
   localparam int C_TRDIS = 3;
   localparam int C_PROP  = 4;
   localparam int C_REPPT = 5;
   localparam int C_REPPG = 6;
   localparam int C_LATCH = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // Status word bit positions; each flag is active low.
   localparam int S_PT = 0;
   localparam int S_PG = 1;
   localparam int S_OC = 2;
   localparam int S_UV = 3;
   localparam int S_OT = 4;
   localparam int S_TR = 5;
   localparam int S_OV = 6;
   localparam int S_STATE = 8;
   localparam logic [6:0] FLAGS_RST = 7'h7F;
   // Threshold word: overvoltage percent low byte, undervoltage percent next.
   localparam logic [7:0] OV_PCT_RST = 8'h78;
   localparam logic [7:0] UV_PCT_RST = 8'h50;
   localparam logic [7:0] OV_PCT_MIN = 8'd110;
   localparam logic [7:0] OV_PCT_MAX = 8'd130;
   localparam logic [7:0] PGH_PCT    = 8'd110;
   localparam logic [7:0] PGL_PCT90  = 8'd90;
   localparam logic [7:0] PGL_PCT95  = 8'd95;
   localparam logic [13:0] OV_FLOOR_MV = 14'd1000;
   localparam logic [11:0] TRACK_MV    = 12'd250;
   // Temperature levels in degrees C.
   localparam logic [7:0] T_WARN_ON  = 8'd120;
   localparam logic [7:0] T_WARN_OFF = 8'd117;
   localparam logic [7:0] T_RESTART  = 8'd110;
   // Retry interval.
   localparam int RETRY_MS = 130;
   localparam int CLK_KHZ  = 10000;
   localparam int RETRY_CYC = RETRY_MS * CLK_KHZ;
   // Off-state machine.
   typedef enum logic [2:0] {
      PFM_RUN  = 3'b001,
      PFM_WAIT = 3'b010,
      PFM_HOLD = 3'b100
   } pfm_state_t;
   // Sense inputs from the analog front end and the sequencer.
   typedef struct packed {
      logic [7:0]  temp_c;
      logic [11:0] vout_mv;
      logic [11:0] vset_mv;
      logic [11:0] ramp_mv;
      logic        cur_limited;
      logic        above_prebias;
      logic        steady;
      logic        ramping_up;
   } pfm_sense_t;
endpackage

// ### logic/pfm_top.sv
// Protection and fault manager: warnings, faults, errors, group fault line.
// Assumes an APB master on pclk and sense inputs from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module pfm_top
   import pfm_pkg::*;
#(
   parameter int RETRY_CYCLES = RETRY_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire pfm_sense_t  sense,
   input  wire logic        turn_on,
   input  wire logic        output_good_pin_i,
   output logic             output_good_pin_o,
   output logic             output_good_pin_oe,
   input  wire logic        group_fault_i,
   output logic             group_fault_o,
   output logic             group_fault_oe,
   output logic             regular_off,
   output logic             fast_off,
   output logic             low_side_on,
   output logic             restart,
   output logic             pm_warning,
   output logic             temp_comp_en
);
   pfm_sense_t  sense_m, sn;
   logic [2:0]  pin_m, pin_s;
   logic [31:0] ctrl;
   logic [15:0] thresh;
   logic [6:0]  flags;
   logic        pt_warn;
   logic        recycled;
   logic        was_on;
   logic        ext_off;
   logic [31:0] timer;
   pfm_state_t  state, next_state;
   logic        apb_wr, apb_rd_set;
   logic [13:0] ov_thr, uv_thr, pgh_thr, pgl_thr;
   logic [7:0]  ov_pct;
   logic [11:0] trk_diff;
   logic        pg_ok, pg_warn;
   logic        det_oc, det_uv, det_ot, det_tr, det_ov;
   logic        any_fast, any_reg, own_fault, grp_low;
   logic        oe_d1, oe_d2;
   logic        cond_ok, may_go;

   // Scales a millivolt value by a percentage.
   function automatic logic [13:0] pct_of(input logic [11:0] mv, input logic [7:0] pct);
      logic [19:0] prod;
      prod = 20'(mv) * 20'(pct);
      return 14'(prod / 20'd100);
   endfunction

   // Two-flop synchronisers; the sense word is assumed slow against pclk.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_m <= '0;
         sn      <= '0;
         pin_m   <= 3'h7;
         pin_s   <= 3'h7;
      end else begin
         sense_m <= sense;
         sn      <= sense_m;
         pin_m   <= {turn_on, group_fault_i, output_good_pin_i};
         pin_s   <= pin_m;
      end
   end

   // Thresholds; the overvoltage percent is clamped and floored at 1.0 V.
   always_comb begin
      ov_pct = thresh[7:0];
      if (ov_pct < OV_PCT_MIN) begin
         ov_pct = OV_PCT_MIN;
      end else if (ov_pct > OV_PCT_MAX) begin
         ov_pct = OV_PCT_MAX;
      end
      ov_thr = pct_of(sn.vset_mv, ov_pct);
      if (ov_thr < OV_FLOOR_MV) begin
         ov_thr = OV_FLOOR_MV;
      end
      uv_thr  = pct_of(sn.vset_mv, thresh[15:8]);
      pgh_thr = pct_of(sn.vset_mv, PGH_PCT);
      pgl_thr = pct_of(sn.vset_mv, ctrl[C_PG95] ? PGL_PCT95 : PGL_PCT90);
   end

   // Window and tracking comparisons.
   always_comb begin
      trk_diff = (sn.vout_mv > sn.ramp_mv) ? sn.vout_mv - sn.ramp_mv
                                           : sn.ramp_mv - sn.vout_mv;
      pg_ok = sn.steady && (14'(sn.vout_mv) <= pgh_thr)
              && (14'(sn.vout_mv) >= pgl_thr);
      pg_warn = !pg_ok || !pin_s[0];
   end

   // Detection of each protection from synchronised inputs.
   always_comb begin
      det_oc = sn.above_prebias && sn.cur_limited
               && (14'(sn.vout_mv) < uv_thr);
      det_uv = sn.steady && !det_oc
               && (14'(sn.vout_mv) < uv_thr);
      det_ot = sn.temp_c > T_WARN_ON;
      det_tr = sn.ramping_up && !ctrl[C_TRDIS]
               && (trk_diff > TRACK_MV);
      det_ov = sn.above_prebias && (14'(sn.vout_mv) > ov_thr);
      grp_low  = !pin_s[1] && !group_fault_oe && !oe_d1 && !oe_d2;
      any_fast = det_oc || det_tr || det_ov;
      any_reg  = det_uv || det_ot || grp_low;
      own_fault = flags[6:2] != 5'h1F;
   end

   // Restart gate: latching classes need a cleared flag or a recycled command.
   always_comb begin
      cond_ok = !(flags[S_OT] == 1'b0 && sn.temp_c >= T_RESTART)
                && !grp_low;
      if ((~flags[6:2] & ctrl[C_LATCH +: 5]) != 5'h00) begin
         may_go = cond_ok && recycled && pin_s[2];
      end else begin
         may_go = cond_ok;
      end
   end

   // Off-state machine: run, wait out the retry time, then hold for the gate.
   always_comb begin
      next_state = state;
      unique case (state)
         PFM_RUN: begin
            if (any_fast || any_reg) begin
               next_state = PFM_WAIT;
            end
         end
         PFM_WAIT: begin
            if (timer == 32'(RETRY_CYCLES - 1)) begin
               next_state = PFM_HOLD;
            end
         end
         PFM_HOLD: begin
            if (may_go) begin
               next_state = PFM_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= PFM_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Retry timer counts only while waiting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer <= '0;
      end else if (state == PFM_WAIT) begin
         timer <= timer + 32'd1;
      end else begin
         timer <= '0;
      end
   end

   // Turn-off commands; fast and error answers come one edge after detection.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regular_off <= 1'b0;
         fast_off    <= 1'b0;
         low_side_on <= 1'b0;
         restart     <= 1'b0;
      end else begin
         restart <= (state == PFM_HOLD) && may_go;
         if (state == PFM_RUN && any_fast) begin
            fast_off    <= 1'b1;
            low_side_on <= det_ov;
         end else if (state == PFM_RUN && any_reg) begin
            regular_off <= 1'b1;
         end else if (state == PFM_HOLD && may_go) begin
            regular_off <= 1'b0;
            fast_off    <= 1'b0;
            low_side_on <= 1'b0;
         end
      end
   end

   // Watches the turn-on command going low and high again while off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         was_on   <= 1'b1;
         recycled <= 1'b0;
      end else begin
         was_on <= pin_s[2];
         if (state == PFM_RUN) begin
            recycled <= 1'b0;
         end else if (pin_s[2] && !was_on) begin
            recycled <= 1'b1;
         end
      end
   end

   // Temperature warning with hysteresis; it never reaches the off logic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pt_warn <= 1'b0;
      end else if (sn.temp_c > T_WARN_ON) begin
         pt_warn <= 1'b1;
      end else if (sn.temp_c < T_WARN_OFF) begin
         pt_warn <= 1'b0;
      end
   end

   // Status flags, active low. Hardware setting a fault beats a software
   // clear in the same cycle; a non-latching restart restores its flags.
   assign apb_wr = psel && penable && pready && pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= FLAGS_RST;
      end else begin
         flags[S_PT] <= !pt_warn;
         flags[S_PG] <= !pg_warn;
         for (int i = S_OC; i <= S_OV; i++) begin
            if (apb_wr && paddr == ADDR_STATUS && pwdata[i]) begin
               flags[i] <= 1'b1;
            end else if (restart && !ctrl[C_LATCH + i - S_OC]) begin
               flags[i] <= 1'b1;
            end
         end
         if (state == PFM_RUN) begin
            if (det_oc) flags[S_OC] <= 1'b0;
            if (det_uv) flags[S_UV] <= 1'b0;
            if (det_ot) flags[S_OT] <= 1'b0;
            if (det_tr) flags[S_TR] <= 1'b0;
            if (det_ov) flags[S_OV] <= 1'b0;
         end
      end
   end

   // Pins and reports; the group line is pulled only for our own fault.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_good_pin_oe <= 1'b1;
         group_fault_oe     <= 1'b0;
         pm_warning         <= 1'b0;
         temp_comp_en       <= 1'b1;
      end else begin
         output_good_pin_oe <= !pg_ok;
         group_fault_oe <= ctrl[C_PROP] && own_fault
                           && state != PFM_RUN;
         pm_warning <= (pt_warn && ctrl[C_REPPT])
                       || (pg_warn && ctrl[C_REPPG]);
         temp_comp_en <= !ctrl[C_TCDIS];
      end
   end
   assign output_good_pin_o = 1'b0;
   assign group_fault_o     = 1'b0;

   // Our own pull stays in the synchronised line copy for two more edges after
   // release; it is masked that long, or a restart after our own pull would trip on its echo.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_d1 <= 1'b0;
         oe_d2 <= 1'b0;
      end else begin
         oe_d1 <= group_fault_oe;
         oe_d2 <= oe_d1;
      end
   end

   // Configuration registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl   <= CTRL_RST;
         thresh <= {UV_PCT_RST, OV_PCT_RST};
      end else if (apb_wr && paddr == ADDR_CTRL) begin
         ctrl <= pwdata & 32'h0000_1F7E;
      end else if (apb_wr && paddr == ADDR_THRESH) begin
         thresh <= pwdata[15:0];
      end
   end

   // APB: read data captured in setup, one access cycle, error if unmapped.
   assign apb_rd_set = psel && !penable;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= apb_rd_set;
         pslverr <= apb_rd_set && paddr != ADDR_CTRL
                    && paddr != ADDR_STATUS && paddr != ADDR_THRESH;
         if (apb_rd_set && !pwrite) begin
            unique case (paddr)
               ADDR_CTRL:   prdata <= ctrl;
               ADDR_STATUS: prdata <= {21'h0, state, 1'b0, flags};
               ADDR_THRESH: prdata <= {16'h0, thresh};
               default:     prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Checks.
   property p_fast_one_cycle;
      @(posedge pclk) disable iff (!presetn)
      (state == PFM_RUN && (det_oc || det_tr)) |=> fast_off && !low_side_on;
   endproperty
   a_fast_one_cycle: assert property (p_fast_one_cycle)
      else $error("fast turn-off late");

   property p_ov_low_side;
      @(posedge pclk) disable iff (!presetn)
      (state == PFM_RUN && det_ov) |=> fast_off && low_side_on && !flags[S_OV];
   endproperty
   a_ov_low_side: assert property (p_ov_low_side)
      else $error("overvoltage answer wrong");

   property p_uv_regular;
      @(posedge pclk) disable iff (!presetn)
      (state == PFM_RUN && det_uv && !any_fast) |=> regular_off && !fast_off;
   endproperty
   a_uv_regular: assert property (p_uv_regular)
      else $error("undervoltage not regular off");

   property p_warn_no_off;
      @(posedge pclk) disable iff (!presetn)
      (state == PFM_RUN && !any_fast && !any_reg) |=> state == PFM_RUN;
   endproperty
   a_warn_no_off: assert property (p_warn_no_off)
      else $error("off without fault");

   property p_pt_hyst;
      @(posedge pclk) disable iff (!presetn)
      (sn.temp_c > T_WARN_ON) ##1 (sn.temp_c >= T_WARN_OFF) |=> !flags[S_PT];
   endproperty
   a_pt_hyst: assert property (p_pt_hyst)
      else $error("temp warning flag wrong");

   property p_pg_pin;
      @(posedge pclk) disable iff (!presetn)
      !sn.steady |=> output_good_pin_oe;
   endproperty
   a_pg_pin: assert property (p_pg_pin)
      else $error("output good pin released early");

   property p_group_pull;
      @(posedge pclk) disable iff (!presetn)
      (ctrl[C_PROP] && state == PFM_WAIT && own_fault) |=> group_fault_oe;
   endproperty
   a_group_pull: assert property (p_group_pull)
      else $error("group line not pulled");

   property p_group_off;
      @(posedge pclk) disable iff (!presetn)
      (state == PFM_RUN && grp_low && !any_fast) |=> regular_off;
   endproperty
   a_group_off: assert property (p_group_off)
      else $error("group line ignored");

   property p_no_early_restart;
      @(posedge pclk) disable iff (!presetn)
      (state == PFM_WAIT && timer < 32'(RETRY_CYCLES - 1)) |=> state == PFM_WAIT;
   endproperty
   a_no_early_restart: assert property (p_no_early_restart)
      else $error("restart before retry time");

   c_fast: cover property (@(posedge pclk) disable iff (!presetn) fast_off);
   c_ov: cover property (@(posedge pclk) disable iff (!presetn) low_side_on);
   c_restart: cover property (@(posedge pclk) disable iff (!presetn) restart);
endmodule
`default_nettype wire

// ### verif/pfm_power_manager.sv
// Model of the power manager and peer modules on the wired lines.
// Assumes open-drain enables from the block, high meaning pull low.
`timescale 1ns/1ps
`default_nettype none
module pfm_power_manager (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic dut_good_oe,
   input  wire logic dut_fault_oe,
   input  wire logic pull_good,
   input  wire logic pull_fault,
   input  wire logic relay_en,
   output logic      good_line,
   output logic      fault_line,
   output logic      other_line
);
   logic relay_pull;
   // Both lines have pull-ups, so a released line reads high, never a stale value.
   assign good_line  = !(dut_good_oe || pull_good);
   assign fault_line = !(dut_fault_oe || pull_fault);
   // A low group line is relayed to the other group a cycle later.
   // The line cannot tell a fault from an error, so peers only see a low level.
   // Front-end stop and crowbar on a relayed error are left to the system.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay_pull <= 1'b0;
      end else begin
         relay_pull <= relay_en && !fault_line;
      end
   end
   assign other_line = !relay_pull;
endmodule
`default_nettype wire

// ### verif/tb_pfm_top.sv
// Self-checking bench for the protection and fault manager.
// Assumes the power manager model and a short retry count of 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_pfm_top import pfm_pkg::*; ;
   localparam logic [31:0] CBASE = (32'h1 << C_PROP) | (32'h1 << C_REPPT) | (32'h1 << C_REPPG);
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        turn_on = 1'b1;
   logic        pull_good = 1'b0;
   logic        pull_fault = 1'b0;
   pfm_sense_t  sense = {8'd25, 12'd1000, 12'd1000, 12'd1000, 4'b0110};
   logic [31:0] prdata, rd;
   logic        pready, pslverr, rerr, good_o, good_oe, fault_o, fault_oe;
   logic        regular_off, fast_off, low_side_on, restart, pm_warning, temp_comp_en;
   wire logic   good_line, fault_line, other_line;
   int          err_total = 0;
   int          num_checks = 0;

   pfm_top #(.RETRY_CYCLES(20)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sense(sense), .turn_on(turn_on), .output_good_pin_i(good_line),
      .output_good_pin_o(good_o), .output_good_pin_oe(good_oe), .group_fault_i(fault_line),
      .group_fault_o(fault_o), .group_fault_oe(fault_oe), .regular_off(regular_off),
      .fast_off(fast_off), .low_side_on(low_side_on), .restart(restart),
      .pm_warning(pm_warning), .temp_comp_en(temp_comp_en));
   pfm_power_manager u_pm (
      .pclk(pclk), .presetn(presetn), .dut_good_oe(good_oe), .dut_fault_oe(fault_oe),
      .pull_good(pull_good), .pull_fault(pull_fault), .relay_en(1'b1),
      .good_line(good_line), .fault_line(fault_line), .other_line(other_line));

   // Free-running 10 MHz clock.
   always #50 pclk = ~pclk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; answer is taken at the rising edge that samples pready high.
   // Only the watchdog ends a wait, so a dead slave still reaches the verdict.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n, 1);
   endtask

   task automatic setctl(input logic [31:0] d);
      apb(1'b1, ADDR_CTRL, d);
   endtask

   task automatic stat(input int b, input logic v);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[b], v);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask

   // Sets temperature, output level and the four sense flags, then waits n cycles.
   task automatic drive(input logic [7:0] t, input logic [11:0] v, input logic [3:0] f,
                        input int n);
      @(posedge pclk);
      sense.temp_c <= t;
      sense.vout_mv <= v;
      {sense.cur_limited, sense.above_prebias, sense.steady, sense.ramping_up} <= f;
      settle(n);
   endtask

   task automatic wait_restart();
      int n;
      n = 0;
      while (restart !== 1'b1 && n < 300) begin
         @(negedge pclk);
         n++;
      end
      chk(restart, 1'b1);
      settle(2);
   endtask

   task automatic t_regs();
      chk(temp_comp_en, 1'b1);
      chk({good_o, fault_o}, 2'b00);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, CTRL_RST);
      apb(1'b0, ADDR_THRESH, 32'h0);
      chk(rd, {16'h0000, UV_PCT_RST, OV_PCT_RST});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({rd[10:8], rd[6:2]}, {3'b001, FLAGS_RST[6:2]});
      apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
      chk(rerr, 1'b1);
      apb(1'b0, 8'h0C, 32'h0);
      chk({rerr, rd[30:0]}, 32'h8000_0000);
      setctl(32'h1 << C_TCDIS);
      settle(1);
      chk(temp_comp_en, 1'b0);
      setctl(CBASE);
   endtask

   task automatic t_output_good_pin();
      settle(4);
      chk(good_oe, 1'b0);
      drive(8'd25, 12'd880, 4'b0110, 6);
      chk({good_oe, pm_warning, regular_off, fast_off}, 4'b1100);
      stat(S_PG, 1'b0);
      drive(8'd25, 12'd1099, 4'b0110, 6);
      chk({good_oe, pm_warning}, 2'b00);
      stat(S_PG, 1'b1);
      drive(8'd25, 12'd1110, 4'b0110, 6);
      chk(good_oe, 1'b1);
      setctl(CBASE | (32'h1 << C_PG95));
      drive(8'd25, 12'd940, 4'b0110, 6);
      chk(good_oe, 1'b1);
      drive(8'd25, 12'd960, 4'b0110, 6);
      chk(good_oe, 1'b0);
      drive(8'd25, 12'd1000, 4'b0100, 6);
      chk(good_oe, 1'b1);
      drive(8'd25, 12'd1000, 4'b0110, 0);
      @(posedge pclk);
      pull_good <= 1'b1;
      settle(6);
      stat(S_PG, 1'b0);
      chk(pm_warning, 1'b1);
      pull_good <= 1'b0;
      setctl(CBASE);
      settle(6);
   endtask

   task automatic t_temp();
      drive(8'd121, 12'd1000, 4'b0110, 6);
      stat(S_PT, 1'b0);
      stat(S_OT, 1'b0);
      chk({pm_warning, regular_off, fast_off, fault_oe}, 4'b1101);
      drive(8'd118, 12'd1000, 4'b0110, 6);
      stat(S_PT, 1'b0);
      drive(8'd116, 12'd1000, 4'b0110, 40);
      stat(S_PT, 1'b1);
      chk(regular_off, 1'b1);
      drive(8'd105, 12'd1000, 4'b0110, 0);
      wait_restart();
      stat(S_OT, 1'b1);
   endtask

   // Overvoltage, threshold clamp and floor, then overcurrent and undervoltage.
   task automatic t_volt();
      drive(8'd25, 12'd1250, 4'b0010, 6);
      chk(fast_off, 1'b0);
      drive(8'd25, 12'd1250, 4'b0110, 6);
      chk({fast_off, low_side_on, fault_oe}, 3'b111);
      stat(S_OV, 1'b0);
      drive(8'd25, 12'd1000, 4'b0110, 0);
      wait_restart();
      apb(1'b1, ADDR_THRESH, {16'h0000, UV_PCT_RST, 8'd140});
      drive(8'd25, 12'd1290, 4'b0110, 6);
      chk(fast_off, 1'b0);
      drive(8'd25, 12'd1310, 4'b0110, 6);
      chk(fast_off, 1'b1);
      apb(1'b1, ADDR_THRESH, {16'h0000, UV_PCT_RST, OV_PCT_MIN});
      sense.vset_mv <= 12'd700;
      drive(8'd25, 12'd700, 4'b0110, 0);
      wait_restart();
      drive(8'd25, 12'd990, 4'b0110, 6);
      chk(fast_off, 1'b0);
      drive(8'd25, 12'd1010, 4'b0110, 6);
      chk(fast_off, 1'b1);
      @(posedge pclk);
      sense.vset_mv <= 12'd1000;
      drive(8'd25, 12'd1000, 4'b0110, 0);
      wait_restart();
      drive(8'd25, 12'd700, 4'b1110, 6);
      chk({fast_off, low_side_on}, 2'b10);
      stat(S_OC, 1'b0);
      stat(S_UV, 1'b1);
      drive(8'd25, 12'd1000, 4'b0110, 0);
      wait_restart();
      drive(8'd25, 12'd700, 4'b0110, 6);
      chk({regular_off, fast_off}, 2'b10);
      stat(S_UV, 1'b0);
      drive(8'd25, 12'd1000, 4'b0110, 0);
      wait_restart();
   endtask

   task automatic t_track();
      drive(8'd25, 12'd750, 4'b0101, 6);
      chk(fast_off, 1'b0);
      drive(8'd25, 12'd740, 4'b0101, 6);
      chk({fast_off, low_side_on}, 2'b10);
      stat(S_TR, 1'b0);
      drive(8'd25, 12'd1000, 4'b0101, 0);
      wait_restart();
      setctl(CBASE | (32'h1 << C_TRDIS));
      drive(8'd25, 12'd600, 4'b0101, 6);
      chk(fast_off, 1'b0);
      drive(8'd25, 12'd1000, 4'b0110, 6);
      setctl(CBASE);
   endtask

   // Group line pulled by a peer, then a latched error that needs turn_on recycled.
   task automatic t_group_latch();
      @(posedge pclk);
      pull_fault <= 1'b1;
      settle(6);
      chk(regular_off, 1'b1);
      @(posedge pclk);
      pull_fault <= 1'b0;
      wait_restart();
      setctl(CBASE | (32'h1 << (C_LATCH + 4)));
      drive(8'd25, 12'd1250, 4'b0110, 6);
      drive(8'd25, 12'd1000, 4'b0110, 60);
      chk(fast_off, 1'b1);
      @(posedge pclk);
      turn_on <= 1'b0;
      settle(4);
      @(posedge pclk);
      turn_on <= 1'b1;
      wait_restart();
      chk(fast_off, 1'b0);
      stat(S_OV, 1'b0);
      apb(1'b1, ADDR_STATUS, 32'h1 << S_OV);
      stat(S_OV, 1'b1);
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence after a 16-cycle reset.
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_output_good_pin();
      t_temp();
      t_volt();
      t_track();
      t_group_latch();
      report_and_stop();
   end

   // The whole run needs several hundred cycles; this cuts a hang short at 20000 cycles.
   initial begin
      #(100 * 20000);
      err_total++;
      report_and_stop();
   end
endmodule
`default_nettype wire
